// *** pkg/sample_fifo_pkg.sv ***
// constants for the optical sample fifo with its serial register port
package sample_fifo_pkg;
  // -------------------------------------------------------------------
  // register indices
  // -------------------------------------------------------------------
  localparam logic [7:0] REG_INT_FLAGS    = 8'h00;
  localparam logic [7:0] REG_INT_MASK     = 8'h02;
  localparam logic [7:0] REG_WRITE_INDEX  = 8'h04;
  localparam logic [7:0] REG_LOST_COUNT   = 8'h05;
  localparam logic [7:0] REG_READ_INDEX   = 8'h06;
  localparam logic [7:0] REG_READ_PORT    = 8'h07;
  localparam logic [7:0] REG_QUEUE_CONFIG = 8'h08;
  localparam logic [7:0] REG_SLOTS_12     = 8'h13;
  localparam logic [7:0] REG_SLOTS_34     = 8'h14;
  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int         ALMOST_FULL_BIT   = 7;
  localparam int         OVERWRITE_BIT     = 4;
  localparam int         AVERAGE_LSB       = 5;
  localparam logic [7:0] QUEUE_CONFIG_RST  = 8'h0F;
  localparam logic [7:0] REG_RST           = 8'h00;
  // -------------------------------------------------------------------
  // fifo geometry and link constants
  // -------------------------------------------------------------------
  localparam int         PTR_W        = 5;
  localparam int         DEPTH        = 32;
  localparam int         ITEM_W       = 24;
  localparam int         SLOTS        = 4;
  localparam int         SAMPLE_W     = ITEM_W * SLOTS;
  localparam logic [5:0] DEPTH_COUNT  = 6'h20;
  localparam logic [4:0] LOST_MAX     = 5'h1F;
  localparam logic [3:0] SLOT_LAST_OK = 4'h8;
  localparam logic [6:0] DEVICE_ADDR  = 7'h57;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BYTES_PER_ITEM = 2'h3;

  typedef enum logic [3:0] {
    LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_REG, LINK_REG_ACK,
    LINK_WDATA, LINK_WDATA_ACK, LINK_TX, LINK_TX_ACK
  } link_state_t;
endpackage : sample_fifo_pkg

// *** rtl/optical_sample_fifo_readout.sv ***
// optical sample fifo, pointers, watermark and serial register port
//
// Function
// - lost-sample counter counts dropped samples and saturates at 0x1F
// - lost-sample counter clears when a complete sample is read out, not on a host write of the read index
// - read index names next sample out, advances per complete sample
// - host may read and write the read index to refetch samples
// - read index is five bits, wraps 0x1F to 0x00
// - read port is read-only, bytes follow programmed slot sequence
// - thirty-two samples stored in time order, slot items in order
// - each item carries 19-bit result, msb at bit 18, upper bits junk
// - unread count is write index minus read index, modulo range, or 32 when full
// - almost full when unread count reaches 32 minus watermark field
// - almost-full event with enable sets flag and drives irq low
// - reading interrupt flags register clears flag, releases irq
// - overwrite mode: sample into full fifo pushed, oldest lost
// - no overwrite: sample into full fifo dropped, fifo unchanged
// - every link byte is eight bits plus one acknowledge clock
// - data line input plus open-drain output, clock line input only
// - write index five bits, advances per pushed sample, wraps
// - each item occupies three bytes of storage
// - register index does not auto-increment on the read port
// - device answers fixed 7-bit address 0b1010111 then rw bit
`timescale 1ns/1ps
module optical_sample_fifo_readout
  import sample_fifo_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic                     irq_out_n,
  input  wire logic                sample_clk,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_items,
  output logic                     sample_ready
);
  // -------------------------------------------------------------------
  // sample domain: capture and toggle handshake
  // -------------------------------------------------------------------
  logic [SAMPLE_W-1:0] hold_r;
  logic                req_r;
  logic                ack_s1_r;
  logic                ack_s2_r;
  logic                ready_r;
  logic                ack_r;

  always_ff @(posedge sample_clk or posedge reset)
  begin
    if (reset)
    begin
      hold_r  <= '0;
      req_r   <= 1'b0;
      ready_r <= 1'b0;
    end
    else if (sample_valid && ready_r)
    begin
      hold_r  <= sample_items;
      req_r   <= ~req_r;
      ready_r <= 1'b0;
    end
    else
    begin
      ready_r <= (ack_s2_r == req_r);
    end
  end

  always_ff @(posedge sample_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  assign sample_ready = ready_r;

  // -------------------------------------------------------------------
  // core domain synchronisers
  // -------------------------------------------------------------------
  logic req_s1_r, req_s2_r;
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {req_s1_r, req_s2_r} <= 2'h0;
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end
    else
    begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  // hold_r is stable while req and ack differ, so reading it here is safe
  wire push = (req_s2_r != ack_r);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ack_r <= 1'b0;
    else
      ack_r <= req_s2_r;
  end

  // -------------------------------------------------------------------
  // registers and fifo state
  // -------------------------------------------------------------------
  logic [SAMPLE_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]    wr_idx_r;
  logic [PTR_W-1:0]    rd_idx_r;
  logic                full_r;
  logic [4:0]          lost_r;
  logic [1:0]          byte_idx_r;
  logic [1:0]          item_idx_r;
  logic [7:0]          mask_r;
  logic [7:0]          config_r;
  logic [7:0]          slots12_r;
  logic [7:0]          slots34_r;
  logic                a_flag_r;
  logic                a_cond_r;
  logic                irq_n_r;

  // bus-side events, produced by the link machine below
  logic       load_now;
  logic [7:0] load_addr;
  logic       wr_now;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // active items: slots up to the first off or reserved code
  logic [2:0] n_items;
  always_comb
  begin
    logic [3:0] s [SLOTS];
    s[0] = slots12_r[3:0];
    s[1] = slots12_r[7:4];
    s[2] = slots34_r[3:0];
    s[3] = slots34_r[7:4];
    n_items = 3'd0;
    for (int i = SLOTS - 1; i >= 0; i--)
      if (s[i] == 4'h0 || s[i] > SLOT_LAST_OK)
        n_items = 3'(i);
    if (n_items == 3'd0 && s[0] != 4'h0 && s[0] <= SLOT_LAST_OK)
      n_items = 3'(SLOTS);
  end

  wire [5:0] unread   = full_r ? DEPTH_COUNT : {1'b0, 5'(wr_idx_r - rd_idx_r)};
  wire       empty    = (unread == 6'h00);
  wire       overwrite_when_full = config_r[OVERWRITE_BIT];
  wire       last_byte = (byte_idx_r == BYTES_PER_ITEM - 2'd1) &&
                         ({1'b0, item_idx_r} == n_items - 3'd1);
  wire       port_read = load_now && load_addr == REG_READ_PORT &&
                         !empty && n_items != 3'd0;
  wire       pop_adv  = port_read && last_byte;
  wire       host_rd  = wr_now && wr_addr == REG_READ_INDEX;
  wire       full_eff = full_r && !pop_adv && !host_rd;
  wire       push_acc = push && (!full_eff || overwrite_when_full);
  wire       roll     = push && full_eff && overwrite_when_full;
  wire       drop     = push && full_eff && !overwrite_when_full;
  wire [PTR_W-1:0] rd_after = host_rd ? wr_data[PTR_W-1:0] :
                              rd_idx_r + PTR_W'(pop_adv | roll);

  // time-ordered storage, one row per sample
  always_ff @(posedge clk)
  begin
    if (push_acc)
      mem[wr_idx_r] <= hold_r;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      full_r   <= 1'b0;
    end
    else
    begin
      if (push_acc)
        wr_idx_r <= wr_idx_r + PTR_W'(1);
      rd_idx_r <= rd_after;
      // overwrite keeps fifo full, drop leaves it alone
      if (push_acc && !roll)
        full_r <= (wr_idx_r + PTR_W'(1)) == rd_after;
      else if (pop_adv || host_rd)
        full_r <= 1'b0;
    end
  end

  // byte and item position within the current sample
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      byte_idx_r <= 2'h0;
      item_idx_r <= 2'h0;
    end
    else if (host_rd || roll || pop_adv)
    begin
      byte_idx_r <= 2'h0;
      item_idx_r <= 2'h0;
    end
    else if (port_read)
    begin
      if (byte_idx_r == BYTES_PER_ITEM - 2'd1)
      begin
        byte_idx_r <= 2'h0;
        item_idx_r <= item_idx_r + 2'd1;
      end
      else
        byte_idx_r <= byte_idx_r + 2'd1;
    end
  end

  // lost count; a loss in the clearing cycle still counts
  // roll moves the read index as well, so it clears before it counts
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lost_r <= 5'h00;
    else if (drop || roll)
      lost_r <= (pop_adv || roll) ? 5'h01 : (lost_r == LOST_MAX ? LOST_MAX : lost_r + 5'h01);
    else if (pop_adv)
      lost_r <= 5'h00;
  end

  // host-writable registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mask_r    <= REG_RST;
      config_r  <= QUEUE_CONFIG_RST;
      slots12_r <= REG_RST;
      slots34_r <= REG_RST;
    end
    else if (wr_now)
    begin
      unique case (wr_addr)
        REG_INT_MASK:     mask_r    <= wr_data;
        REG_QUEUE_CONFIG: config_r  <= wr_data;
        REG_SLOTS_12:     slots12_r <= wr_data;
        REG_SLOTS_34:     slots34_r <= wr_data;
        default:          ;
      endcase
    end
  end

  wire a_cond  = unread >= (DEPTH_COUNT - {2'b00, config_r[3:0]});
  wire a_en    = mask_r[ALMOST_FULL_BIT];
  wire a_set   = a_cond && !a_cond_r && a_en;
  wire a_clear = load_now && load_addr == REG_INT_FLAGS;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      a_cond_r <= 1'b0;
      a_flag_r <= 1'b0;
      irq_n_r  <= 1'b1;
    end
    else
    begin
      a_cond_r <= a_cond;
      // set wins over the read clear
      if (a_set)
        a_flag_r <= 1'b1;
      else if (a_clear)
        a_flag_r <= 1'b0;
      irq_n_r <= ~((a_set || (a_flag_r && !a_clear)) && a_en);
    end
  end

  assign irq_out_n = irq_n_r;

  // read port byte, item msb first
  logic [SAMPLE_W-1:0] cur_sample;
  logic [ITEM_W-1:0]   cur_item;
  logic [7:0]          port_byte;
  always_comb
  begin
    cur_sample = mem[rd_idx_r];
    unique case (item_idx_r)
      2'd0:    cur_item = cur_sample[95:72];
      2'd1:    cur_item = cur_sample[71:48];
      2'd2:    cur_item = cur_sample[47:24];
      default: cur_item = cur_sample[23:0];
    endcase
    unique case (byte_idx_r)
      2'd0:    port_byte = cur_item[23:16];
      2'd1:    port_byte = cur_item[15:8];
      default: port_byte = cur_item[7:0];
    endcase
    if (empty || n_items == 3'd0)
      port_byte = 8'h00;
  end

  logic [7:0] read_value;
  always_comb
  begin
    unique case (load_addr)
      REG_INT_FLAGS:    read_value = {a_flag_r, 7'h00};
      REG_INT_MASK:     read_value = {mask_r[7:4], 4'h0};
      REG_WRITE_INDEX:  read_value = {3'h0, wr_idx_r};
      REG_LOST_COUNT:   read_value = {3'h0, lost_r};
      REG_READ_INDEX:   read_value = {3'h0, rd_idx_r};
      REG_READ_PORT:    read_value = port_byte;
      REG_QUEUE_CONFIG: read_value = config_r;
      REG_SLOTS_12:     read_value = slots12_r;
      REG_SLOTS_34:     read_value = slots34_r;
      default:          read_value = 8'h00;
    endcase
  end

  // -------------------------------------------------------------------
  // serial link machine, oversampled on clk
  // -------------------------------------------------------------------
  link_state_t state_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  ptr_r;
  logic        ptr_set_r;
  logic        rw_r;
  logic        sda_oe_r;
  logic        sda_out_r;

  wire scl_rise = scl_s2_r && !scl_d_r;
  wire scl_fall = !scl_s2_r && scl_d_r;
  wire start_ev = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  wire stop_ev  = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
  wire byte_in  = scl_fall && bit_cnt_r == BITS_PER_BYTE;

  // load points: after address ack of a read, or after master ack
  always_comb
  begin
    load_now  = 1'b0;
    load_addr = ptr_r;
    if (!start_ev && !stop_ev && scl_fall)
    begin
      if (state_r == LINK_ADDR_ACK && rw_r)
      begin
        load_now  = 1'b1;
        load_addr = ptr_set_r ? ptr_r : 8'h00;
      end
      else if (state_r == LINK_TX_ACK)
        load_now = 1'b1;
    end
  end

  // third and later bytes of a write frame
  assign wr_now  = !start_ev && !stop_ev && state_r == LINK_WDATA && byte_in;
  assign wr_addr = ptr_r;
  assign wr_data = shift_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r   <= LINK_IDLE;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      bit_cnt_r <= 4'h0;
      ptr_r     <= 8'h00;
      ptr_set_r <= 1'b0;
      rw_r      <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r   <= LINK_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r   <= LINK_IDLE;
      ptr_set_r <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else
    begin
      if (load_now)
      begin
        // no auto-increment on the read port
        ptr_r     <= (load_addr == REG_READ_PORT) ? load_addr : load_addr + 8'h01;
        tx_r      <= read_value;
        sda_oe_r  <= ~read_value[7];
        bit_cnt_r <= 4'h0;
        state_r   <= LINK_TX;
      end
      unique case (state_r)
        LINK_IDLE: ;
        LINK_ADDR, LINK_REG, LINK_WDATA:
        begin
          // eight bits sampled on rising clock
          if (scl_rise)
          begin
            shift_r   <= {shift_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_in)
          begin
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b1;
            if (state_r == LINK_ADDR)
            begin
              // fixed address match, else stay off the bus
              if (shift_r[7:1] == DEVICE_ADDR)
              begin
                rw_r    <= shift_r[0];
                state_r <= LINK_ADDR_ACK;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                state_r  <= LINK_IDLE;
              end
            end
            else if (state_r == LINK_REG)
            begin
              ptr_r     <= shift_r;
              ptr_set_r <= 1'b1;
              state_r   <= LINK_REG_ACK;
            end
            else
            begin
              if (ptr_r != REG_READ_PORT)
                ptr_r <= ptr_r + 8'h01;
              state_r <= LINK_WDATA_ACK;
            end
          end
        end
        LINK_ADDR_ACK, LINK_REG_ACK, LINK_WDATA_ACK:
        begin
          if (scl_fall && !load_now)
          begin
            sda_oe_r <= 1'b0;
            state_r  <= (state_r == LINK_ADDR_ACK) ? LINK_REG : LINK_WDATA;
          end
        end
        LINK_TX:
        begin
          // open drain: enable drives the line low
          if (scl_fall)
          begin
            if (bit_cnt_r == BITS_PER_BYTE - 4'h1)
            begin
              sda_oe_r <= 1'b0;
              state_r  <= LINK_TX_ACK;
            end
            else
            begin
              tx_r      <= {tx_r[6:0], 1'b0};
              sda_oe_r  <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        LINK_TX_ACK:
        begin
          // not-ack ends the read; wait for stop
          if (scl_rise && sda_s2_r)
            state_r <= LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sda_out_r <= 1'b0;
    else
      sda_out_r <= 1'b0;
  end

  assign sda_out = sda_out_r;
  assign sda_oe  = sda_oe_r;
endmodule : optical_sample_fifo_readout

// *** tb/host_bus_model.sv ***
// serial bus master model standing in for the host processor
`timescale 1ns/1ps
module host_bus_model
  import sample_fifo_pkg::*;
#(
  parameter int Q = 650
)
(
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  logic [7:0] rx [16];
  logic [7:0] junk;
  logic       ack;
  int         n_nack = 0;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task start_c;
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_c

  task stop_c;
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop_c

  task bit_x(input logic b, output logic o);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q o = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_x

  task xfer(input logic [7:0] b, input logic a, output logic [7:0] o);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], o[i]);
    bit_x(a, ack);
  endtask : xfer

  task put(input logic [7:0] b);
    xfer(b, 1'b1, junk);
    if (ack !== 1'b0)
      n_nack++;
  endtask : put

  task wr(input logic [7:0] r, input logic [7:0] d);
    start_c();
    put({DEVICE_ADDR, 1'b0});
    put(r);
    put(d);
    stop_c();
  endtask : wr

  task rd(input logic [7:0] r, input int n);
    start_c();
    put({DEVICE_ADDR, 1'b0});
    put(r);
    start_c();
    put({DEVICE_ADDR, 1'b1});
    for (int k = 0; k < n; k++)
      xfer(8'hFF, k == n - 1, rx[k]);
    stop_c();
  endtask : rd
endmodule : host_bus_model

// *** tb/optical_sample_fifo_readout_monitor.sv ***
// port checker for the optical sample fifo
`timescale 1ns/1ps
module optical_sample_fifo_readout_monitor
  import sample_fifo_pkg::*;
(
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe,
  input wire logic                irq_out_n,
  input wire logic                sample_clk,
  input wire logic                sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_items,
  input wire logic                sample_ready
);
  // ----
  // serial side
  // ----
  // open drain only
  chk_drain_only: assert property (@(posedge clk) disable iff (reset)
    sda_out == 1'b0) else $error("sda driven high");
  chk_oe_rise_low: assert property (@(posedge clk) disable iff (reset)
    $rose(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("sda pulled while clock high");
  chk_oe_steady: assert property (@(posedge clk) disable iff (reset)
    scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("sda moved while clock high");
  chk_irq_release: assert property (@(posedge clk) disable iff (reset)
    $rose(irq_out_n) |-> !scl_in) else $error("irq released outside a bus access");
  chk_quiet_start: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> (!sda_oe && irq_out_n) [*4]) else $error("outputs busy after reset");
  // ----
  // sample side
  // ----
  // one take per handshake
  chk_take_drop: assert property (@(posedge sample_clk) disable iff (reset)
    sample_valid && sample_ready |=> !sample_ready) else $error("ready held after take");
  chk_ready_back: assert property (@(posedge sample_clk) disable iff (reset)
    sample_valid && sample_ready |=> ##[1:24] sample_ready) else $error("ready never back");
  chk_ready_late: assert property (@(posedge sample_clk) disable iff (reset)
    $fell(reset) |-> !sample_ready) else $error("ready too early");

  cov_irq: cover property (@(posedge clk) disable iff (reset) $fell(irq_out_n));
  cov_ack: cover property (@(posedge clk) disable iff (reset) $rose(sda_oe));
  cov_take: cover property (@(posedge sample_clk) disable iff (reset)
    sample_valid && sample_ready);
endmodule : optical_sample_fifo_readout_monitor

bind optical_sample_fifo_readout optical_sample_fifo_readout_monitor
  optical_sample_fifo_readout_monitor_i (.clk, .reset, .scl_in, .sda_in, .sda_out,
  .sda_oe, .irq_out_n, .sample_clk, .sample_valid, .sample_items, .sample_ready);

// *** tb/optical_sample_fifo_readout_test.sv ***
// self-checking bench for the optical sample fifo readout
`timescale 1ns/1ps
module optical_sample_fifo_readout_test
  import sample_fifo_pkg::*;
();
  typedef struct packed {logic [7:0] r; logic w; logic [7:0] v;} row_t;
  // register accesses: index, write, data or expected read
  row_t rows [12] = '{{8'h08, 1'b0, 8'h0F}, {8'h05, 1'b0, 8'h00}, {8'h13, 1'b1, 8'h21},
    {8'h14, 1'b1, 8'h03}, {8'h02, 1'b1, 8'h80}, {8'h08, 1'b1, 8'h0C},
    {8'h05, 1'b1, 8'h1F}, {8'h05, 1'b0, 8'h00}, {8'h06, 1'b1, 8'h1F},
    {8'h06, 1'b0, 8'h1F}, {8'h06, 1'b1, 8'h00}, {8'h02, 1'b0, 8'h80}};
  logic                clk = 1'b0;
  logic                sample_clk = 1'b0;
  logic                reset;
  logic                sample_valid;
  logic [SAMPLE_W-1:0] sample_items;
  logic                scl;
  logic                sda_drv;
  logic                sda_line;
  logic                sda_out;
  logic                sda_oe;
  logic                irq_out_n;
  logic                sample_ready;
  int                  failures;
  int                  n_checks;
  int                  i;

  always #20 clk = ~clk;
  // sample clock offset so its edges drift against clk
  initial
  begin
    #7;
    forever #16 sample_clk = ~sample_clk;
  end
  // pull-up: line low only when someone pulls it
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

  optical_sample_fifo_readout optical_sample_fifo_readout_i (.clk(clk), .reset(reset),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .irq_out_n(irq_out_n), .sample_clk(sample_clk), .sample_valid(sample_valid),
    .sample_items(sample_items), .sample_ready(sample_ready));
  host_bus_model host_bus_model_i (.sda(sda_line), .scl(scl), .sda_drv(sda_drv));

  function automatic logic [95:0] smp(input int n);
    logic [7:0] t;
    t = 8'(n);
    smp = {t, 8'h10, 8'hC1, t, 8'h20, 8'hC2, t, 8'h30, 8'hC3, t, 8'h40, 8'hC4};
  endfunction : smp

  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8

  task cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1

  task wr(input logic [7:0] r, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_bus_model_i.wr(r, d);
  endtask : wr

  task rd(input logic [7:0] r, input int n);
    @(posedge clk);
    #1;
    host_bus_model_i.rd(r, n);
  endtask : rd

  task rdc(input logic [7:0] r, input logic [7:0] e);
    rd(r, 1);
    cmp8(host_bus_model_i.rx[0], e);
  endtask : rdc

  task push(input int n);
    int t;
    @(posedge sample_clk);
    #1;
    sample_valid = 1'b1;
    sample_items = smp(n);
    for (t = 0; t < 40 && sample_ready !== 1'b1; t++)
      @(negedge sample_clk);
    cmp1(sample_ready, 1'b1);
    @(posedge sample_clk);
    #1;
    sample_valid = 1'b0;
    sample_items = ~sample_items;
  endtask : push

  // top five bits of an item carry no result, so masked
  task chk_item(input int n, input int k, input int at);
    logic [95:0] s;
    logic [7:0]  m;
    s = smp(n);
    for (int b = 0; b < 3; b++)
    begin
      m = (b == 0) ? 8'h07 : 8'hFF;
      cmp8(host_bus_model_i.rx[at + b] & m, s[95 - 24 * k - 8 * b -: 8] & m);
    end
  endtask : chk_item

  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial
  begin
    #3800000;
    failures++;
    $display("Error t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end

  initial
  begin
    failures = 0;
    n_checks = 0;
    reset = 1'b1;
    sample_valid = 1'b0;
    sample_items = '0;
    repeat (20) @(posedge clk);
    cmp1(sda_oe, 1'b0);
    cmp1(irq_out_n, 1'b1);
    cmp1(sample_ready, 1'b0);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < 12; i++)
    begin
      if (rows[i].w)
        wr(rows[i].r, rows[i].v);
      else
        rdc(rows[i].r, rows[i].v);
    end
    $display("test registers done");
    for (i = 0; i < 19; i++)
      push(i);
    rdc(8'h04, 8'h13);
    cmp1(irq_out_n, 1'b1);
    push(19);
    for (i = 0; i < 40 && irq_out_n !== 1'b0; i++)
      @(posedge clk);
    cmp1(irq_out_n, 1'b0);
    rdc(8'h00, 8'h80);
    cmp1(irq_out_n, 1'b1);
    rdc(8'h00, 8'h00);
    $display("test watermark done");
    rdc(8'h05, 8'h00);
    rd(8'h07, 12);
    chk_item(0, 0, 0);
    chk_item(0, 1, 3);
    chk_item(0, 2, 6);
    chk_item(1, 0, 9);
    rdc(8'h06, 8'h01);
    wr(8'h06, 8'h00);
    rd(8'h07, 3);
    chk_item(0, 0, 0);
    $display("test readout done");
    for (i = 20; i < 65; i++)
      push(i);
    rdc(8'h04, 8'h00);
    rdc(8'h05, 8'h1F);
    $display("test drop done");
    wr(8'h08, 8'h1C);
    push(65);
    rdc(8'h06, 8'h01);
    rdc(8'h05, 8'h01);
    rd(8'h07, 9);
    for (i = 0; i < 3; i++)
      chk_item(1, i, 3 * i);
    rdc(8'h06, 8'h02);
    rdc(8'h05, 8'h00);
    $display("test overwrite done");
    @(posedge clk);
    #1;
    host_bus_model_i.start_c();
    host_bus_model_i.put(8'hA0);
    host_bus_model_i.stop_c();
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    cmp1(sda_oe, 1'b0);
    cmp1(irq_out_n, 1'b1);
    cmp1(sample_ready, 1'b0);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h0F);
    cmp8(8'(host_bus_model_i.n_nack), 8'h01);
    $display("test second reset done");
    stop_test();
  end
endmodule : optical_sample_fifo_readout_test
